// ---- design/gtc_timer.sv ----
/*
  Gated 16-bit timer/counter with prescaler, optional external clock
  synchronisation, buffered 16-bit access and gate modes.
  Assumes pins and comparator outputs are asynchronous; the second timer
  match is on core_clk_i. Crystal/clock-in selection is a strap input.
*/
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Source 00 instruction clock, 01 system clock
// - Source 10 counts pin or oscillator edges
// - Prescaler divides by 1, 2, 4, 8
// - Oscillator enable powers crystal driver
// - Sync-disable bit matters only for source 10
// - Wide-access bit selects 16-bit buffered access
// - Counting only while run bit set
// - Gate enable gates counting when running
// - Polarity bit selects active gate level
// - Toggle mode divides gate by flip-flop
// - Single-pulse mode controls the gate
// - Arm bit clears when done or mode off
// - Gate level bit shows gate state
// - Gate source select picks four inputs
// - Special event trigger clears counter
// - Low-byte access moves high byte buffer
// - Only low-byte write clears prescaler
// - Falling edge needed before first count
module gtc_timer
  import gtc_pkg::*;
(
  input  wire logic          core_clk_i,
  input  wire logic          rst_b_i,
  input  wire logic [2:0]    reg_addr_i,
  input  wire logic [7:0]    reg_wdata_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  output logic [7:0]         reg_rdata_o,
  input  wire logic          ext_count_input_i,
  input  wire logic          crystal_in_pin_i,
  input  wire logic          ext_clock_in_pin_i,
  input  wire logic          osc_drive_select_i,
  input  wire gtc_gate_src_t gate_src_i,
  input  wire logic          special_event_trigger_i,
  output logic               osc_driver_enable_o,
  output logic [15:0]        count_o,
  output logic               overflow_o
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic [2:0] gsrc_s1_reg;
  logic [2:0] gsrc_s2_reg;

  // First stage feeds the second stage and also the unsynchronised capture from pin_s1_reg[2]
  always_ff @(posedge core_clk_i)
  begin
    pin_s1_reg  <= {ext_count_input_i, crystal_in_pin_i, ext_clock_in_pin_i};
    pin_s2_reg  <= pin_s1_reg;
    gsrc_s1_reg <= {gate_src_i.cmp2, gate_src_i.cmp1, gate_src_i.pin};
    gsrc_s2_reg <= gsrc_s1_reg;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  gtc_ctrl_t   ctrl_reg;
  gtc_gate_t   gate_reg;
  logic [15:0] count_reg;
  logic [7:0]  hi_buf_reg;
  logic        ovf_reg;
  logic [1:0]  instr_div_reg;
  logic [2:0]  presc_reg;
  logic        ext_prev_reg;
  logic        ext_ready_reg;
  logic        ext_unsync_reg;
  logic        toggle_ff_reg;
  logic        gate_prev_reg;
  logic        pulse_open_reg;
  logic        gate_val_reg;
  logic        osc_strap_reg;

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  wire       instr_tick = (instr_div_reg == GTC_INSTR_DIV_LAST);
  // Oscillator or clock-in pin, chosen by a strap input sampled every cycle out of reset
  wire       osc_level  = osc_strap_reg ? pin_s2_reg[1] : pin_s2_reg[0];
  wire       ext_sync_l = ctrl_reg.secondary_osc_enable ? osc_level : pin_s2_reg[2];
  // Unsynchronised path still needs one capture; it matches the synchronised pin latency and adds one stage for the oscillator
  wire       ext_level  = ctrl_reg.ext_clock_sync_disable ? ext_unsync_reg : ext_sync_l;
  wire       ext_rise   = ext_level & ~ext_prev_reg & ext_ready_reg;
  logic      src_tick;
  always_comb
  begin
    case (ctrl_reg.clock_source_select)
      GTC_SRC_INSTR: src_tick = instr_tick;
      GTC_SRC_SYS:   src_tick = 1'b1;
      GTC_SRC_EXT:   src_tick = ext_rise;
      default:       src_tick = instr_tick;  // 11 treated as instruction clock
    endcase
  end

  // ----------------------------------------------------------------
  // Gate path
  // ----------------------------------------------------------------
  logic gate_raw;
  always_comb
  begin
    case (gate_reg.gate_source_select)
      2'h0:    gate_raw = gsrc_s2_reg[0];
      2'h1:    gate_raw = gate_src_i.timer2_match;
      2'h2:    gate_raw = gsrc_s2_reg[1];
      default: gate_raw = gsrc_s2_reg[2];
    endcase
  end
  wire gate_pol   = gate_reg.gate_polarity ? gate_raw : ~gate_raw;
  wire gate_rise  = gate_pol & ~gate_prev_reg;
  wire gate_tm    = gate_reg.gate_toggle_mode ? toggle_ff_reg : gate_pol;
  // Single-pulse mode: only the armed window lets counts through
  wire gate_final = gate_reg.gate_single_pulse_mode ? (pulse_open_reg & gate_tm) : gate_tm;
  wire pulse_start = gate_reg.single_pulse_arm_done & ~pulse_open_reg & gate_tm;
  wire pulse_end   = pulse_open_reg & ~gate_tm;
  wire count_en   = ctrl_reg.counter_run & (~gate_reg.gate_enable | gate_final);

  // ----------------------------------------------------------------
  // Prescaler and counter step
  // ----------------------------------------------------------------
  logic presc_tick;
  always_comb
  begin
    case (ctrl_reg.input_prescale_select)
      2'h0:    presc_tick = 1'b1;
      2'h1:    presc_tick = presc_reg[0];
      2'h2:    presc_tick = &presc_reg[1:0];
      default: presc_tick = &presc_reg;
    endcase
  end
  wire step = count_en & src_tick & presc_tick;
  wire pre_step = count_en & src_tick;

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  wire wr_ctrl = reg_wr_i & (reg_addr_i == GTC_ADDR_CTRL);
  wire wr_gate = reg_wr_i & (reg_addr_i == GTC_ADDR_GATE);
  wire wr_lo   = reg_wr_i & (reg_addr_i == GTC_ADDR_CNT_LO);
  wire wr_hi   = reg_wr_i & (reg_addr_i == GTC_ADDR_CNT_HI);
  wire rd_lo   = reg_rd_i & (reg_addr_i == GTC_ADDR_CNT_LO);
  wire rd_stat = reg_rd_i & (reg_addr_i == GTC_ADDR_STAT);
  wire wide    = ctrl_reg.wide_access_enable;
  wire run_chg = wr_ctrl & (reg_wdata_i[0] != ctrl_reg.counter_run);

  logic [7:0] rd_mux;
  always_comb
  begin
    case (reg_addr_i)
      GTC_ADDR_CTRL:   rd_mux = ctrl_reg;
      GTC_ADDR_GATE:   rd_mux = {gate_reg[7:3], gate_val_reg, gate_reg[1:0]};
      GTC_ADDR_CNT_LO: rd_mux = count_reg[7:0];
      GTC_ADDR_CNT_HI: rd_mux = wide ? hi_buf_reg : count_reg[15:8];
      GTC_ADDR_STAT:   rd_mux = {7'h00, ovf_reg};
      default:         rd_mux = 8'h00;
    endcase
  end

  // Counter next value: software write wins over counting
  logic [15:0] count_next;
  always_comb
  begin
    count_next = count_reg;
    if (special_event_trigger_i)
      count_next = GTC_CNT_RST;
    else if (wr_lo)
      count_next = wide ? {hi_buf_reg, reg_wdata_i} : {count_reg[15:8], reg_wdata_i};
    else if (wr_hi && !wide)
      count_next = {reg_wdata_i, count_reg[7:0]};
    else if (step)
      count_next = count_reg + 16'h0001;
  end
  wire rollover = step & (&count_reg) & ~special_event_trigger_i & ~wr_lo & ~(wr_hi & ~wide);

  // ----------------------------------------------------------------
  // Control and gate registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_reg <= GTC_CTRL_RST;
      gate_reg <= GTC_GATE_RST;
      osc_strap_reg <= 1'b0;
    end
    else
    begin
      osc_strap_reg <= osc_drive_select_i;
      if (wr_ctrl)
        ctrl_reg <= reg_wdata_i;
      if (wr_gate)
        gate_reg <= {reg_wdata_i[7:3], 1'b0, reg_wdata_i[1:0]};
      // Arm bit: hardware clear on completion or mode off
      if (!(wr_gate ? reg_wdata_i[4] : gate_reg.gate_single_pulse_mode) || pulse_end)
        gate_reg.single_pulse_arm_done <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Counting state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      count_reg      <= GTC_CNT_RST;
      hi_buf_reg     <= 8'h00;
      ovf_reg        <= 1'b0;
      instr_div_reg  <= 2'h0;
      presc_reg      <= 3'h0;
      ext_prev_reg   <= 1'b1;
      ext_ready_reg  <= 1'b0;
      ext_unsync_reg <= 1'b0;
      toggle_ff_reg  <= 1'b0;
      gate_prev_reg  <= 1'b0;
      pulse_open_reg <= 1'b0;
      gate_val_reg   <= 1'b0;
      reg_rdata_o    <= 8'h00;
      count_o        <= GTC_CNT_RST;
      overflow_o     <= 1'b0;
      osc_driver_enable_o <= 1'b0;
    end
    else
    begin
      count_reg     <= count_next;
      instr_div_reg <= instr_div_reg + 2'h1;
      if (wr_lo)
        presc_reg <= 3'h0;
      else if (pre_step)
        presc_reg <= presc_reg + 3'h1;
      if (rd_lo && wide)
        hi_buf_reg <= count_reg[15:8];
      else if (wr_hi && wide)
        hi_buf_reg <= reg_wdata_i;
      // Set wins over a clear by status read in the same cycle
      if (rollover)
        ovf_reg <= 1'b1;
      else if (rd_stat)
        ovf_reg <= 1'b0;
      ext_unsync_reg <= pin_s1_reg[2] & ~ctrl_reg.secondary_osc_enable
                      | (ctrl_reg.secondary_osc_enable & osc_level);
      ext_prev_reg <= ext_level;
      // Any count write or run change re-arms the falling-edge wait
      if (wr_lo || wr_hi || run_chg)
        ext_ready_reg <= 1'b0;
      else if (!ext_level)
        ext_ready_reg <= 1'b1;
      gate_prev_reg <= gate_pol;
      if (!gate_reg.gate_toggle_mode)
        toggle_ff_reg <= 1'b0;
      else if (gate_rise)
        toggle_ff_reg <= ~toggle_ff_reg;
      if (!gate_reg.gate_single_pulse_mode || pulse_end)
        pulse_open_reg <= 1'b0;
      else if (pulse_start)
        pulse_open_reg <= 1'b1;
      gate_val_reg <= gate_final;
      reg_rdata_o  <= reg_rd_i ? rd_mux : 8'h00;
      count_o      <= count_next;
      overflow_o   <= rollover;
      osc_driver_enable_o <= ctrl_reg.secondary_osc_enable;
    end
  end
endmodule // gtc_timer

`default_nettype wire

// ---- design/gtc_pkg.sv ----
/*
  Package for the gated 16-bit timer/counter: register indices, field
  positions, reset values and carrier types.
  Assumes a single 25 MHz core clock and an 8-bit register port.
*/
package gtc_pkg;
  // ----------------------------------------------------------------
  // Register map (index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [2:0] GTC_ADDR_CTRL   = 3'h0;
  localparam logic [2:0] GTC_ADDR_GATE   = 3'h1;
  localparam logic [2:0] GTC_ADDR_CNT_LO = 3'h2;
  localparam logic [2:0] GTC_ADDR_CNT_HI = 3'h3;
  localparam logic [2:0] GTC_ADDR_STAT   = 3'h4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  GTC_CTRL_RST = 8'h00;
  localparam logic [7:0]  GTC_GATE_RST = 8'h00;
  localparam logic [15:0] GTC_CNT_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // Clock source and prescale encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] GTC_SRC_INSTR = 2'h0;
  localparam logic [1:0] GTC_SRC_SYS   = 2'h1;
  localparam logic [1:0] GTC_SRC_EXT   = 2'h2;
  localparam logic [1:0] GTC_INSTR_DIV_LAST = 2'h3;  // System clock / 4

  // ----------------------------------------------------------------
  // Field layouts (bit 7 first)
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] clock_source_select;
    logic [1:0] input_prescale_select;
    logic       secondary_osc_enable;
    logic       ext_clock_sync_disable;
    logic       wide_access_enable;
    logic       counter_run;
  } gtc_ctrl_t;

  typedef struct packed {
    logic       gate_enable;
    logic       gate_polarity;
    logic       gate_toggle_mode;
    logic       gate_single_pulse_mode;
    logic       single_pulse_arm_done;
    logic       gate_level;
    logic [1:0] gate_source_select;
  } gtc_gate_t;

  // Raw gate candidates from outside
  typedef struct packed {
    logic cmp2;
    logic cmp1;
    logic timer2_match;
    logic pin;
  } gtc_gate_src_t;
endpackage : gtc_pkg

// ---- test/gtc_timer_monitor.sv ----
/* Port-level checker for gtc_timer.
   Assumes software reaches the block only through the register port. */
`timescale 1ns/1ps
`default_nettype none
module gtc_timer_monitor
  import gtc_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  input wire logic [2:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        special_event_trigger_i,
  input wire logic        osc_driver_enable_o,
  input wire logic [15:0] count_o,
  input wire logic        overflow_o
);
  gtc_ctrl_t  ctrl_reg;
  gtc_gate_t  gate_reg;
  logic [7:0] buf_reg;
  logic [3:0] age_reg;  // Quiet cycles since a write or clear
  wire        wide_w = ctrl_reg.wide_access_enable;
  wire        free_w = ctrl_reg.counter_run && !gate_reg.gate_enable && age_reg == 4'hF;

  // Shadow software state, since the design's copies are hidden
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_reg <= GTC_CTRL_RST;
      gate_reg <= GTC_GATE_RST;
      buf_reg  <= 8'h00;
      age_reg  <= 4'h0;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == GTC_ADDR_CTRL)
        ctrl_reg <= gtc_ctrl_t'(reg_wdata_i);
      if (reg_wr_i && reg_addr_i == GTC_ADDR_GATE)
        gate_reg <= gtc_gate_t'(reg_wdata_i);
      if (wide_w && reg_wr_i && reg_addr_i == GTC_ADDR_CNT_HI)
        buf_reg <= reg_wdata_i;
      if (wide_w && reg_rd_i && reg_addr_i == GTC_ADDR_CNT_LO)
        buf_reg <= count_o[15:8];
      age_reg <= (reg_wr_i || special_event_trigger_i) ? 4'h0 : age_reg + {3'h0, age_reg != 4'hF};
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  property p_rst;
    disable iff (1'b0) !rst_b_i |=> count_o == 16'h0000 && !overflow_o && reg_rdata_o == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("output not cleared by reset");
  property p_rate;
    free_w && ctrl_reg.clock_source_select == GTC_SRC_SYS
      |-> count_o == $past(count_o, 8) + (16'h0008 >> ctrl_reg.input_prescale_select);
  endproperty
  a_rate: assert property (p_rate) else $error("wrong prescaled count rate");
  property p_instr;
    free_w && ctrl_reg.clock_source_select == GTC_SRC_INSTR && ctrl_reg.input_prescale_select == 2'h0
      |-> count_o == $past(count_o, 4) + 16'h0001;
  endproperty
  a_instr: assert property (p_instr) else $error("wrong instruction clock rate");
  property p_stop;
    !ctrl_reg.counter_run && age_reg > 4'h6 |-> $stable(count_o);
  endproperty
  a_stop: assert property (p_stop) else $error("count moved while stopped");
  property p_trig;
    special_event_trigger_i |=> count_o == 16'h0000;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger did not clear count");
  property p_ovf;
    $past(count_o) == 16'hFFFF && count_o == 16'h0000 && age_reg != 4'h0 |-> ##[0:1] overflow_o;
  endproperty
  a_ovf: assert property (p_ovf) else $error("rollover without overflow pulse");
  property p_osc;
    age_reg > 4'h1 |-> osc_driver_enable_o == ctrl_reg.secondary_osc_enable;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator driver disagrees");
  property p_hi_rd;
    reg_rd_i && reg_addr_i == GTC_ADDR_CNT_HI && wide_w |=> reg_rdata_o == $past(buf_reg);
  endproperty
  a_hi_rd: assert property (p_hi_rd) else $error("high byte read not from buffer");
  property p_lo_wr;
    reg_wr_i && reg_addr_i == GTC_ADDR_CNT_LO && wide_w && !special_event_trigger_i
      |=> count_o == {$past(buf_reg), $past(reg_wdata_i)};
  endproperty
  a_lo_wr: assert property (p_lo_wr) else $error("low byte write did not load 16 bits");
  property p_arm;
    reg_rd_i && reg_addr_i == GTC_ADDR_GATE && !gate_reg.gate_single_pulse_mode |=> !reg_rdata_o[3];
  endproperty
  a_arm: assert property (p_arm) else $error("arm bit set without single pulse");
endmodule // gtc_timer_monitor

bind gtc_timer gtc_timer_monitor u_mon (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .special_event_trigger_i(special_event_trigger_i),
  .osc_driver_enable_o(osc_driver_enable_o), .count_o(count_o), .overflow_o(overflow_o));
`default_nettype wire

// ---- test/gtc_far_model.sv ----
/* Far side: count pin bursts and a free-running crystal.
   Assumes the bench calls burst() from its main thread. */
`timescale 1ns/1ps
`default_nettype none
module gtc_far_model (
  output logic ext_count_input_o,
  output logic crystal_in_pin_o
);
  // Crystal runs free, slow enough for the core clock to sample
  initial
  begin
    crystal_in_pin_o = 1'b0;
    forever #173 crystal_in_pin_o = ~crystal_in_pin_o;
  end

  // Pin idles low, so a falling edge always precedes a burst
  initial
    ext_count_input_o = 1'b0;
  task automatic burst(input int n);
    for (int i = 0; i < n; i++)
    begin
      #97 ext_count_input_o = 1'b1;
      #131 ext_count_input_o = 1'b0;
    end
  endtask
endmodule // gtc_far_model
`default_nettype wire

// ---- test/gtc_timer_bench.sv ----
/* Self-checking bench for gtc_timer with random and corner stimulus.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("unexpected at %0t: %h not %h", $time, g, e); \
    end \
  end
module gtc_timer_bench
  import gtc_pkg::*;
;
  logic          clk, rst_b, wr, rd, xo_sel, trig, ecnt, xtal, osc_en, ovf;
  logic [2:0]    adr;
  logic [7:0]    wd, rdat, d;
  logic [15:0]   cnt, c0;
  gtc_gate_src_t gsrc;
  int            err_count, n_checks, cyc, g;

  gtc_far_model u_far (.ext_count_input_o(ecnt), .crystal_in_pin_o(xtal));
  gtc_timer u_dut (.core_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(adr), .reg_wdata_i(wd), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdat), .ext_count_input_i(ecnt), .crystal_in_pin_i(xtal),
    .ext_clock_in_pin_i(1'b0), .osc_drive_select_i(xo_sel), .gate_src_i(gsrc),
    .special_event_trigger_i(trig), .osc_driver_enable_o(osc_en), .count_o(cnt), .overflow_o(ovf));

  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      print_verdict();
    end
  end

  function automatic logic [7:0] fctl(logic [1:0] s, logic [1:0] p, logic [3:0] low);
    return {s, p, low};
  endfunction

  // Register port cycles; read data lands in d
  task automatic wreg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    adr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  task automatic pulse();
    @(posedge clk);
    gsrc <= 4'h1;
    repeat (8) @(posedge clk);
    gsrc <= 4'h0;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    {rst_b, wr, rd, trig, adr, wd, gsrc} = '0;
    xo_sel = 1'b1;
    void'($urandom(47));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rreg(GTC_ADDR_CTRL);
    `CHK(d, GTC_CTRL_RST)
    rreg(GTC_ADDR_GATE);
    `CHK(d & 8'hFB, GTC_GATE_RST)
    for (g = 0; g < 5; g++)
    begin
      wreg(GTC_ADDR_CTRL, fctl(g == 4 ? GTC_SRC_INSTR : GTC_SRC_SYS, 2'(g), 4'h1));
      repeat (24) @(posedge clk);
    end
    wreg(GTC_ADDR_CTRL, 8'h00);
    repeat (6) #40;
    c0 = cnt;
    repeat (20) #40;
    `CHK(cnt, c0)
    $display("rate test done");
    c0 = 16'($urandom);
    wreg(GTC_ADDR_CTRL, 8'h02);
    wreg(GTC_ADDR_CNT_HI, c0[15:8]);
    wreg(GTC_ADDR_CNT_LO, c0[7:0]);
    #1;
    `CHK(cnt, c0)
    rreg(GTC_ADDR_CNT_LO);
    `CHK(d, c0[7:0])
    rreg(GTC_ADDR_CNT_HI);
    `CHK(d, c0[15:8])
    wreg(GTC_ADDR_CNT_HI, 8'hFF);
    wreg(GTC_ADDR_CNT_LO, 8'hF8);
    // The trigger below stands for a capture unit, so the system clock is not used
    wreg(GTC_ADDR_CTRL, 8'h03);
    #1;
    for (g = 0; g < 40 && ovf !== 1'b1; g++)
      #40;
    `CHK(ovf, 1'b1)
    rreg(GTC_ADDR_STAT);
    `CHK(d, 8'h01)
    rreg(GTC_ADDR_STAT);
    `CHK(d, 8'h00)
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    #1;
    `CHK(cnt, 16'h0000)
    $display("wide test done");
    for (g = 0; g < 8; g++)
    begin
      @(posedge clk);
      gsrc <= 4'($urandom);
      wreg(GTC_ADDR_GATE, {1'b1, g[2], 4'h0, g[1:0]});
      repeat (6) @(posedge clk);
      rreg(GTC_ADDR_GATE);
      `CHK(d[2], gsrc[g[1:0]] ~^ g[2])
    end
    @(posedge clk);
    gsrc <= 4'h0;
    wreg(GTC_ADDR_GATE, 8'hD8);
    repeat (6) #40;
    c0 = cnt;
    rreg(GTC_ADDR_GATE);
    `CHK({d[3], cnt}, {1'b1, c0})
    pulse();
    `CHK(cnt == c0, 1'b0)
    rreg(GTC_ADDR_GATE);
    `CHK(d[3], 1'b0)
    c0 = cnt;
    pulse();
    `CHK(cnt, c0)
    wreg(GTC_ADDR_GATE, 8'hC8);
    rreg(GTC_ADDR_GATE);
    `CHK(d[3], 1'b0)
    $display("gate test done");
    for (g = 0; g < 2; g++)
    begin
      wreg(GTC_ADDR_GATE, 8'h00);
      wreg(GTC_ADDR_CTRL, fctl(GTC_SRC_EXT, 2'h0, {1'b0, g[0], 2'b01}));
      repeat (4) #40;
      c0 = cnt;
      u_far.burst(6);
      repeat (8) #40;
      `CHK(cnt, c0 + 16'h0006)
    end
    wreg(GTC_ADDR_CTRL, 8'h89);
    #1;
    c0 = cnt;
    repeat (60) #40;
    `CHK(cnt == c0, 1'b0)
    $display("external test done");
    print_verdict();
  end
endmodule // gtc_timer_bench
`default_nettype wire
